/* File: design/bpc_regs.vh */
`ifndef BPC_REGS_VH
`define BPC_REGS_VH
// register byte addresses
`define BPC_ADDR_PERF        8'h8C
`define BPC_ADDR_PM_CTRL_STATUS_REG       8'h90
`define BPC_ADDR_IRQ_STAT    8'h94
`define BPC_ADDR_IRQ_MASK    8'h98
`define BPC_ADDR_PM_CTRL     8'h9C
// field positions
`define BPC_LAT_LSB          16
`define BPC_LAT_MSB          31
`define BPC_DW_LSB           0
`define BPC_DW_MSB           7
`define BPC_WAKE_BIT         15
`define BPC_SCALE_LSB        13
`define BPC_SCALE_MSB        14
`define BPC_POWER_STATE_FIELD_LSB         0
`define BPC_POWER_STATE_FIELD_MSB         1
`define BPC_WEN_BIT          0
// reset and fixed values
`define BPC_PERF_RST         16'h0000
`define BPC_DW_RST           8'h00
`define BPC_SCALE_VAL        2'h0
`define BPC_POWER_STATE_FIELD_RST         2'h0
`define BPC_POWER_STATE_FIELD_D0          2'h0
`define BPC_POWER_STATE_FIELD_D3HOT       2'h3
// interrupt status bit positions
`define BPC_IRQ_WAKE         0
`define BPC_IRQ_LAT_SAT      1
`define BPC_IRQ_DW_SAT       2
`endif

/* File: design/bpc_sat_counter.v */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// saturating accumulator, cleared by a read strobe; adds that coincide with
// the clear start the new interval instead of being lost
module bpc_sat_counter #(
  parameter W = 8
) (
  input  wire         ref_clk_i,   // clock
  input  wire         resetn_i,    // async reset, active low
  input  wire         ce_i,        // clock enable
  input  wire         clr_i,       // clear on register read
  input  wire [W-1:0] add_i,       // amount to accumulate
  output reg  [W-1:0] count_o,     // registered count
  output reg          sat_o        // registered, high for one cycle after each add that overflows
);
  wire [W:0] sum_w;                // widened sum for overflow detect
  wire [W:0] base_w;               // zero when clearing
  assign base_w = clr_i ? {(W+1){1'b0}} : {1'b0, count_o};
  assign sum_w  = base_w + {1'b0, add_i};

  // accumulate, clamp at all ones
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= {W{1'b0}};
      sat_o   <= 1'b0;
    end else if (ce_i) begin
      if (sum_w[W]) begin
        count_o <= {W{1'b1}};
        sat_o   <= 1'b1;
      end else begin
        count_o <= sum_w[W-1:0];
        sat_o   <= 1'b0;
      end
    end
  end
endmodule // bpc_sat_counter

/* File: design/bpc_perf_pm.v */
`timescale 1ns/1ps
`include "bpc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R01 - count clocks from read request to completion
// R02 - latency sums all reads since last read
// R03 - count dwords of bus-master data transactions
// R04 - dword count sums since last read
// R05 - counts read-only, reset zero, clear on read
// R06 - wake flag set on every wake event
// R07 - write one clears wake flag, drops wake signal
// R08 - data scale field reads fixed zero
// R09 - power state 00..11, bad writes discarded
// R10 - reserved bits read zero, writes ignored
module bpc_perf_pm (
  input  wire        ref_clk_i,         // 100 MHz clock
  input  wire        resetn_i,          // async reset, active low
  input  wire        ce_i,              // clock enable, freezes state when low
  input  wire [7:0]  addr_i,            // register byte address
  input  wire [31:0] wdata_i,           // write data
  input  wire        wr_i,              // write strobe
  input  wire        rd_i,              // read strobe
  output reg  [31:0] rdata_o,           // read data, cycle after strobe
  input  wire        mrd_req_i,         // master read request asserted (pulse)
  input  wire        mrd_done_i,        // master read access completed (pulse)
  input  wire        mdw_xfer_i,        // one dword moved by bus master
  input  wire        wake_event_i,      // wake-up event detected (pulse)
  input  wire [3:0]  power_state_field_supported_i,  // one bit per supported power state
  output reg  [1:0]  power_state_o,     // current power state
  output wire        pme_n_o,           // wake signal, active low
  output wire        pme_oe_o,          // wake signal drive enable
  output wire        irq_o              // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function hit;                         // address match
    input [7:0] a;
    input [7:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  function power_state_field_ok;                     // state is in the supported set
    input [1:0] s;
    input [3:0] sup;
    begin
      power_state_field_ok = sup[s];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg         in_read_reg;              // a master read is outstanding
  reg         wake_flag_reg;            // sticky wake status
  reg         wake_en_reg;              // wake signal enable
  reg  [2:0]  irq_stat_reg;             // sticky interrupt status
  reg  [2:0]  irq_mask_reg;             // interrupt mask, 1 = enabled
  reg  [31:0] rdata_next;               // read mux output
  wire [15:0] lat_count;                // accumulated read latency
  wire [7:0]  dw_count;                 // accumulated dwords
  wire        lat_sat;                  // latency counter saturated
  wire        dw_sat;                   // dword counter saturated
  wire        perf_rd;                  // read of the counter register
  wire        pm_wr;                    // write of the pm register
  wire        wake_clr;                 // write one to wake flag
  wire [2:0]  irq_events;               // event pulses for status
  wire        lat_tick;                 // clock spent in a read

  assign perf_rd  = rd_i && hit(addr_i, `BPC_ADDR_PERF);
  assign pm_wr    = wr_i && hit(addr_i, `BPC_ADDR_PM_CTRL_STATUS_REG);
  assign wake_clr = pm_wr && wdata_i[`BPC_WAKE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // master read tracking: count every clock from request to completion
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_read_reg <= 1'b0;
    end else if (ce_i) begin
      if (mrd_done_i) begin
        in_read_reg <= 1'b0;                       // [R01]
      end else if (mrd_req_i) begin
        in_read_reg <= 1'b1;                       // [R01]
      end
    end
  end

  // the request clock itself counts and the completion clock does not, so the
  // sum is the clocks elapsed; a request that completes at once counts one
  assign lat_tick = mrd_req_i || (in_read_reg && !mrd_done_i);  // [R01]

  ////////////////////////////////////////////////////////////////////////////
  // accumulators, cleared by reading the counter register
  bpc_sat_counter #(
    .W (16)
  ) u_lat_cnt (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .clr_i     (perf_rd),                          // [R02] [R05]
    .add_i     ({15'h0000, lat_tick}),             // [R01] [R02]
    .count_o   (lat_count),
    .sat_o     (lat_sat)
  );

  bpc_sat_counter #(
    .W (8)
  ) u_dw_cnt (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .clr_i     (perf_rd),                          // [R04] [R05]
    .add_i     ({7'h00, mdw_xfer_i}),              // [R03] [R04]
    .count_o   (dw_count),
    .sat_o     (dw_sat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake flag: set wins over a same-cycle clear
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_flag_reg <= 1'b0;                       // [R06]
    end else if (ce_i) begin
      if (wake_event_i) begin
        wake_flag_reg <= 1'b1;                     // [R06]
      end else if (wake_clr) begin
        wake_flag_reg <= 1'b0;                     // [R07]
      end
    end
  end

  // wake signal driven low only while enabled and flagged, open-drain style
  assign pme_n_o  = 1'b0;
  assign pme_oe_o = wake_flag_reg && wake_en_reg;  // [R07]

  ////////////////////////////////////////////////////////////////////////////
  // power state and wake enable writes
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_state_o <= `BPC_POWER_STATE_FIELD_RST;
      wake_en_reg   <= 1'b0;
    end else if (ce_i) begin
      if (pm_wr &&
          power_state_field_ok(wdata_i[`BPC_POWER_STATE_FIELD_MSB:`BPC_POWER_STATE_FIELD_LSB], power_state_field_supported_i)) begin
        power_state_o <= wdata_i[`BPC_POWER_STATE_FIELD_MSB:`BPC_POWER_STATE_FIELD_LSB];  // [R09]
      end
      if (wr_i && hit(addr_i, `BPC_ADDR_PM_CTRL)) begin
        wake_en_reg <= wdata_i[`BPC_WEN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  assign irq_events[`BPC_IRQ_WAKE]    = wake_event_i;
  assign irq_events[`BPC_IRQ_LAT_SAT] = lat_sat;
  assign irq_events[`BPC_IRQ_DW_SAT]  = dw_sat;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
      // each bit: event sets, write one clears, set wins
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          irq_stat_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          if (irq_events[gi]) begin
            irq_stat_reg[gi] <= 1'b1;
          end else if (wr_i && hit(addr_i, `BPC_ADDR_IRQ_STAT) && wdata_i[gi]) begin
            irq_stat_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // mask register
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_reg <= 3'h0;
    end else if (ce_i && wr_i && hit(addr_i, `BPC_ADDR_IRQ_MASK)) begin
      irq_mask_reg <= wdata_i[2:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved and unmapped bits read zero
  always @* begin
    rdata_next = 32'h00000000;                     // [R10]
    if (hit(addr_i, `BPC_ADDR_PERF)) begin
      rdata_next[`BPC_LAT_MSB:`BPC_LAT_LSB] = lat_count;   // [R01] [R05]
      rdata_next[`BPC_DW_MSB:`BPC_DW_LSB]   = dw_count;    // [R03] [R05]
    end else if (hit(addr_i, `BPC_ADDR_PM_CTRL_STATUS_REG)) begin
      rdata_next[`BPC_WAKE_BIT]                  = wake_flag_reg;   // [R06]
      rdata_next[`BPC_SCALE_MSB:`BPC_SCALE_LSB]  = `BPC_SCALE_VAL;  // [R08]
      rdata_next[`BPC_POWER_STATE_FIELD_MSB:`BPC_POWER_STATE_FIELD_LSB]    = power_state_o;   // [R09]
    end else if (hit(addr_i, `BPC_ADDR_IRQ_STAT)) begin
      rdata_next[2:0] = irq_stat_reg;
    end else if (hit(addr_i, `BPC_ADDR_IRQ_MASK)) begin
      rdata_next[2:0] = irq_mask_reg;
    end else if (hit(addr_i, `BPC_ADDR_PM_CTRL)) begin
      rdata_next[`BPC_WEN_BIT] = wake_en_reg;
    end
  end

  // read data register, loaded on a read strobe and zeroed on other enabled cycles
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= rdata_next;
      end else begin
        rdata_o <= 32'h00000000;
      end
    end
  end
endmodule // bpc_perf_pm

/* File: testbench/bpc_perf_pm_sva.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// shadow counters and port checks
module bpc_perf_pm_sva (
  input wire        ref_clk_i,
  input wire        resetn_i,
  input wire        ce_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        mrd_req_i,
  input wire        mrd_done_i,
  input wire        mdw_xfer_i,
  input wire        wake_event_i,
  input wire [3:0]  power_state_field_supported_i,
  input wire [1:0]  power_state_o,
  input wire        pme_n_o,
  input wire        pme_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  reg  [15:0] lat_q;  // expected latency sum
  reg  [7:0]  dw_q;   // expected dword sum
  reg         outs_q; // master read outstanding
  reg         wake_q; // expected wake flag
  wire rp = rd_i & ce_i & (addr_i == 8'h8C);
  wire pr = rd_i & ce_i & (addr_i == 8'h90);
  wire pw = wr_i & ce_i & (addr_i == 8'h90);
  wire la = mrd_req_i | (outs_q & ~mrd_done_i); // completion clock not counted
  // a read starts a new interval with that cycle's events
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lat_q  <= 16'h0000;
      dw_q   <= 8'h00;
      outs_q <= 1'h0;
      wake_q <= 1'h0;
    end else if (ce_i) begin
      lat_q  <= (rp ? 16'h0000 : lat_q) + {15'h0000, la};
      dw_q   <= (rp ? 8'h00 : dw_q) + {7'h00, mdw_xfer_i};
      outs_q <= (mrd_req_i | outs_q) & ~mrd_done_i;
      wake_q <= wake_event_i | (wake_q & ~(pw & wdata_i[15]));
    end
  end
  perf_read_a: assert property ($past(rp) |->
    rdata_o == {$past(lat_q), 8'h00, $past(dw_q)}) else $error("perf read wrong");
  wake_read_a: assert property ($past(pr) |->
    rdata_o[15] == $past(wake_q)) else $error("wake flag read wrong");
  pm_fixed_a: assert property ($past(pr) |-> rdata_o[31:16] == 16'h0000
    && rdata_o[14:2] == 13'h0000 && rdata_o[1:0] == $past(power_state_o))
    else $error("pm fixed fields wrong");
  unmapped_zero_a: assert property ($past(rd_i & ce_i & (addr_i[7:5] != 3'h4)) |->
    rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  power_state_field_keep_a: assert property (pw && !power_state_field_supported_i[wdata_i[1:0]] |=>
    $stable(power_state_o)) else $error("bad power state taken");
  power_state_field_take_a: assert property (pw && power_state_field_supported_i[wdata_i[1:0]] |=>
    power_state_o == $past(wdata_i[1:0])) else $error("power state not taken");
  wake_drop_a: assert property ($fell(pme_oe_o) |->
    $past(wr_i & ce_i & (addr_i[7:4] == 4'h9))) else $error("wake drive dropped alone");
  wake_drive_a: assert property (wake_event_i && ce_i ##1 wr_i && ce_i &&
    addr_i == 8'h9C && wdata_i[0] |=> pme_oe_o) else $error("wake not driven");
  pin_level_a: assert property (pme_n_o == 1'h0) else $error("wake pin level");
endmodule // bpc_perf_pm_sva
bind bpc_perf_pm bpc_perf_pm_sva chk (.*);

/* File: testbench/bpc_master_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////
// bus-master side: master reads and dword beats
module bpc_master_model (
  input  wire ref_clk_i,  // clock
  output reg  mrd_req_o,  // read request pulse
  output reg  mrd_done_o, // completion pulse
  output reg  mdw_xfer_o  // one pulse per dword
);
  initial begin
    mrd_req_o  = 1'h0;
    mrd_done_o = 1'h0;
    mdw_xfer_o = 1'h0;
  end
  // request, then completion lat cycles later
  task read_access(input integer lat);
    begin
      @(posedge ref_clk_i);
      mrd_req_o <= 1'h1;
      repeat (lat) @(posedge ref_clk_i) mrd_req_o <= 1'h0;
      mrd_done_o <= 1'h1;
      @(posedge ref_clk_i);
      mrd_done_o <= 1'h0;
    end
  endtask
  // n back-to-back dword beats
  task dword_beats(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i) mdw_xfer_o <= 1'h1;
      @(posedge ref_clk_i);
      mdw_xfer_o <= 1'h0;
    end
  endtask
endmodule // bpc_master_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin \
  n_fail = n_fail + 1; $display("unexpected at %0t: %h %h", $time, g, e); end end
////////////////////////////////////////
module tb;
  reg         ref_clk_i = 1'h0;
  reg         resetn_i = 1'h0;
  reg         ce_i = 1'h1;
  reg  [7:0]  addr_i = 8'h00;
  reg  [31:0] wdata_i = 32'h0;
  reg         wr_i = 1'h0;
  reg         rd_i = 1'h0;
  reg         wake_event_i = 1'h0;
  reg  [3:0]  power_state_field_supported_i = 4'hB; // state 2 unsupported
  wire [31:0] rdata_o;
  wire [1:0]  power_state_o;
  wire        mrd_req, mrd_done, mdw_xfer, pme_oe_o, irq_o;
  integer     n_fail = 0;
  integer     check_count = 0;
  integer     i;
  reg  [1:0]  ps;
  always #5 ref_clk_i = ~ref_clk_i;
  bpc_master_model bfm (.ref_clk_i(ref_clk_i), .mrd_req_o(mrd_req),
    .mrd_done_o(mrd_done), .mdw_xfer_o(mdw_xfer));
  bpc_perf_pm dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .mrd_req_i(mrd_req), .mrd_done_i(mrd_done), .mdw_xfer_i(mdw_xfer),
    .wake_event_i(wake_event_i), .power_state_field_supported_i(power_state_field_supported_i),
    .power_state_o(power_state_o), .pme_n_o(), .pme_oe_o(pme_oe_o), .irq_o(irq_o));
  ////////////////////////////////////////
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'h0;
      @(negedge ref_clk_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge ref_clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'h0;
      @(negedge ref_clk_i);
      `CHK(rdata_o, e)
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    #100000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    rd(8'h8C, 32'h0);
    rd(8'h90, 32'h0);
    rd(8'h40, 32'h0);
    fork
      bfm.read_access(3);
      bfm.dword_beats(4);
    join
    bfm.read_access(1);
    bfm.read_access(5);
    bfm.dword_beats(3);
    rd(8'h8C, {16'h0009, 8'h00, 8'h07});
    rd(8'h8C, 32'h0);
    wr(8'h8C, 32'hFFFF_FFFF);
    rd(8'h8C, 32'h0);
    wr(8'h90, 32'hFFFF_7FFC);
    rd(8'h90, 32'h0);
    // wake event, then enable the wake drive at once
    @(posedge ref_clk_i);
    wake_event_i <= 1'h1;
    @(posedge ref_clk_i);
    wake_event_i <= 1'h0;
    wr_i <= 1'h1;
    addr_i <= 8'h9C;
    wdata_i <= 32'h1;
    @(posedge ref_clk_i);
    wr_i <= 1'h0;
    @(negedge ref_clk_i);
    `CHK({pme_oe_o, irq_o}, 2'h2)
    rd(8'h90, 32'h8000);
    wr(8'h98, 32'h1);
    `CHK(irq_o, 1'h1)
    wr(8'h90, 32'h0);
    `CHK(pme_oe_o, 1'h1)
    wr(8'h90, 32'h8000);
    `CHK(pme_oe_o, 1'h0)
    rd(8'h90, 32'h0);
    wr(8'h94, 32'h1);
    `CHK(irq_o, 1'h0)
    // every power-state code, the unsupported one discarded
    ps = 2'h0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (power_state_field_supported_i[i]) ps = i[1:0];
      wr(8'h90, i);
      `CHK(power_state_o, ps)
      rd(8'h90, {30'h0, ps});
    end
    // clock enable low: beats and writes must leave no trace
    @(posedge ref_clk_i);
    ce_i <= 1'h0;
    bfm.dword_beats(2);
    wr(8'h90, 32'h3);
    `CHK(power_state_o, 2'h0)
    @(posedge ref_clk_i);
    ce_i <= 1'h1;
    rd(8'h8C, 32'h0);
    print_verdict;
  end
endmodule // tb
